// *** src/qof_pkg.sv ***
// Shared constants and state encoding for the queue occupancy controller.
package qof_pkg;

  localparam int unsigned QOF_CNT_W   = 8;
  localparam logic [7:0]  QOF_CNT_MAX = 8'hfa;
  localparam logic [7:0]  QOF_CNT_MIN = 8'h00;

  localparam int unsigned QOF_NUM_ST  = 5;

  // One-hot state codes; the bit position of each state is also its status flag position.
  localparam int unsigned QOF_BIT_DRAINED   = 0;
  localparam int unsigned QOF_BIT_SATURATED = 1;
  localparam int unsigned QOF_BIT_QUIESCENT = 2;
  localparam int unsigned QOF_BIT_READING   = 3;
  localparam int unsigned QOF_BIT_WRITING   = 4;

  typedef enum logic [4:0] {
    QOF_DRAINED   = 5'h01,
    QOF_SATURATED = 5'h02,
    QOF_QUIESCENT = 5'h04,
    QOF_READING   = 5'h08,
    QOF_WRITING   = 5'h10
  } qof_state_t;

  localparam qof_state_t QOF_RST_STATE = QOF_DRAINED;
  localparam logic [4:0] QOF_RST_FLAGS = 5'h01;

endpackage

// *** src/qof_flags.sv ***
// Registered one-hot status flags following the controller's next state.
`timescale 1ns/1ps
module qof_flags
  import qof_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  qof_state_t      state_d,
  output logic [4:0]      flags_q
);

  logic [4:0] flags_d;

  // Decoding the next state keeps the flags aligned with the state register, yet glitch free.
  always_comb begin
    flags_d = 5'h00;
    for (int i = 0; i < QOF_NUM_ST; i++) begin
      flags_d[i] = state_d[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      flags_q <= QOF_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// *** src/qof_fsm.sv ***
// Five-state Moore controller reporting a FIFO's occupancy condition.
`timescale 1ns/1ps
module qof_fsm
  import qof_pkg::*;
#(
  parameter int unsigned CNT_W   = QOF_CNT_W,
  parameter int unsigned CNT_MAX = 250
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [CNT_W-1:0] count_in,
  output logic                  st_drained,
  output logic                  st_saturated,
  output logic                  st_quiescent,
  output logic                  st_reading,
  output logic                  st_writing
);

  // Refused at elaboration: the top count must be representable and nonzero.
  if (CNT_W < 1 || CNT_W > 31 || CNT_MAX >= (2 ** CNT_W) || CNT_MAX < 1) begin : g_bad_cnt
    $error("qof_fsm: occupancy maximum does not fit the count width");
  end

  localparam logic [CNT_W-1:0] CNT_TOP  = CNT_W'(CNT_MAX);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(QOF_CNT_MIN);

  qof_state_t state_q;
  qof_state_t state_d;
  logic [4:0] flags_q;

  logic at_top;
  logic at_zero;
  logic no_req;

  // Counts above the top are out of contract; they are simply treated as not full.
  assign at_top  = (count_in == CNT_TOP);
  assign at_zero = (count_in == CNT_ZERO);
  assign no_req  = !push && !pop;

  // Overlapping requests resolve in the order the conditions are listed per state.
  always_comb begin
    state_d = state_q;
    case (state_q)
      QOF_DRAINED: begin
        if (push && !at_top) begin
          state_d = QOF_WRITING;
        end else if (no_req) begin
          state_d = QOF_QUIESCENT;
        end
      end
      QOF_SATURATED: begin
        if (no_req) begin
          state_d = QOF_QUIESCENT;
        end else if (pop) begin
          state_d = QOF_READING;
        end
      end
      QOF_QUIESCENT: begin
        if (pop && at_zero) begin
          state_d = QOF_DRAINED;
        end else if (push && at_top) begin
          state_d = QOF_SATURATED;
        end else if (push) begin
          state_d = QOF_WRITING;
        end else if (pop) begin
          state_d = QOF_READING;
        end
      end
      QOF_READING: begin
        if (no_req) begin
          state_d = QOF_QUIESCENT;
        end else if (pop && at_zero) begin
          state_d = QOF_DRAINED;
        end else if (push && at_top) begin
          state_d = QOF_SATURATED;
        end else if (push) begin
          state_d = QOF_WRITING;
        end else begin
          state_d = QOF_READING;
        end
      end
      QOF_WRITING: begin
        if (no_req) begin
          state_d = QOF_QUIESCENT;
        end else if (pop && at_zero) begin
          state_d = QOF_DRAINED;
        end else if (push && at_top) begin
          state_d = QOF_SATURATED;
        end else if (push) begin
          state_d = QOF_WRITING;
        end else begin
          state_d = QOF_READING;
        end
      end
      default: begin
        // An illegal code can only come from an upset; recover to the safe state.
        state_d = QOF_RST_STATE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= QOF_RST_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  qof_flags u_flags (
    .mclk    (mclk),
    .srst    (srst),
    .state_d (state_d),
    .flags_q (flags_q)
  );

  assign st_drained   = flags_q[QOF_BIT_DRAINED];
  assign st_saturated = flags_q[QOF_BIT_SATURATED];
  assign st_quiescent = flags_q[QOF_BIT_QUIESCENT];
  assign st_reading   = flags_q[QOF_BIT_READING];
  assign st_writing   = flags_q[QOF_BIT_WRITING];

  logic [4:0] flags_seen;
  assign flags_seen = {st_writing, st_reading, st_quiescent, st_saturated, st_drained};

  chk_reset_drained: assert property (@(posedge mclk) srst |=> st_drained &&
      state_q == QOF_DRAINED)
    else $error("reset did not reach the drained state");

  chk_flags_onehot: assert property (@(posedge mclk) disable iff (srst)
      $onehot(flags_seen))
    else $error("status flags are not one-hot");

  chk_flags_track: assert property (@(posedge mclk) disable iff (srst)
      flags_seen == state_q)
    else $error("status flags disagree with the state register");

  chk_drained_write: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_DRAINED && push && !at_top |=> st_writing)
    else $error("drained write below top did not enter writing");

  chk_drained_idle: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_DRAINED && !push && !pop |=> st_quiescent)
    else $error("drained with no requests did not go quiescent");

  chk_sat_read: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_SATURATED && pop |=> st_reading)
    else $error("saturated read did not enter reading");

  chk_quiet_full: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_QUIESCENT && push && at_top |=> st_saturated)
    else $error("quiescent write at top did not saturate");

  chk_read_drain: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_READING && pop && !push && at_zero |=> st_drained)
    else $error("read at zero did not drain");

  chk_write_stay: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_WRITING && push && !at_top && !(pop && at_zero) |=> st_writing)
    else $error("write below top left the writing state");

  chk_write_read: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_WRITING && pop && !push && !at_zero |=> st_reading)
    else $error("read at nonzero count did not enter reading");

  chk_sat_hold: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_SATURATED && push && !pop |=> $stable(state_q))
    else $error("saturated state moved without a listed condition");

  chk_drained_hold: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_DRAINED && !(push && !at_top) && !no_req |=> st_drained)
    else $error("drained state moved without a listed condition");

  chk_sat_idle: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_SATURATED && no_req |=> st_quiescent)
    else $error("saturated with no requests did not go quiescent");

  chk_quiet_drain: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_QUIESCENT && pop && at_zero |=> st_drained)
    else $error("quiescent read at zero did not drain");

  chk_quiet_write: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_QUIESCENT && push && !at_top && !(pop && at_zero) |=> st_writing)
    else $error("quiescent write below top did not enter writing");

  chk_quiet_read: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_QUIESCENT && pop && !push && !at_zero |=> st_reading)
    else $error("quiescent read at nonzero count did not enter reading");

  chk_read_idle: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_READING && no_req |=> st_quiescent)
    else $error("reading with no requests did not go quiescent");

  chk_read_full: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_READING && push && at_top |=> st_saturated)
    else $error("reading write at top did not saturate");

  chk_read_write: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_READING && push && !at_top && !(pop && at_zero) |=> st_writing)
    else $error("reading write below top did not enter writing");

  chk_read_stay: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_READING && pop && !push && !at_zero |=> st_reading)
    else $error("read at nonzero count left the reading state");

  chk_write_idle: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_WRITING && no_req |=> st_quiescent)
    else $error("writing with no requests did not go quiescent");

  chk_write_full: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_WRITING && push && at_top |=> st_saturated)
    else $error("writing at top did not saturate");

  chk_write_drain: assert property (@(posedge mclk) disable iff (srst)
      state_q == QOF_WRITING && pop && at_zero |=> st_drained)
    else $error("writing read at zero did not drain");

  cov_fill_up: cover property (@(posedge mclk) disable iff (srst)
      st_drained ##1 st_writing [*3] ##1 st_saturated);

  cov_drain_down: cover property (@(posedge mclk) disable iff (srst)
      st_saturated ##1 st_reading ##[1:20] st_drained);

  cov_rest: cover property (@(posedge mclk) disable iff (srst)
      st_writing ##1 st_quiescent [*3] ##1 st_writing);

endmodule

// *** verif/qof_dp_model.sv ***
// Datapath stand-in that presents requests and occupancy one cycle after a command.
`timescale 1ns/1ps
module qof_dp_model (
  input  wire logic       mclk,
  input  wire logic       wr_cmd,
  input  wire logic       rd_cmd,
  input  wire logic [7:0] lvl_cmd,
  output logic            push,
  output logic            pop,
  output logic [7:0]      count_in
);
  // A real datapath never reports more than a full queue, so the level is clipped.
  always_ff @(posedge mclk) begin
    push     <= wr_cmd;
    pop      <= rd_cmd;
    count_in <= (lvl_cmd > 8'hfa) ? 8'hfa : lvl_cmd;
  end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the queue occupancy controller.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb
  import qof_pkg::*;
;
  localparam logic [4:0] D = QOF_DRAINED;
  localparam logic [4:0] S = QOF_SATURATED;
  localparam logic [4:0] Q = QOF_QUIESCENT;
  localparam logic [4:0] R = QOF_READING;
  localparam logic [4:0] W = QOF_WRITING;
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       wr_cmd = 1'b1;
  logic       rd_cmd = 1'b0;
  logic [7:0] lvl_cmd = 8'hfa;
  logic       push, pop;
  logic [7:0] count_in;
  logic [4:0] flags;
  int         num_errors = 0;
  int         tests_run = 0;

  qof_dp_model u_qof_dp_model (.mclk(mclk), .wr_cmd(wr_cmd), .rd_cmd(rd_cmd),
    .lvl_cmd(lvl_cmd), .push(push), .pop(pop), .count_in(count_in));
  qof_fsm u_qof_fsm (.mclk(mclk), .srst(srst), .push(push), .pop(pop), .count_in(count_in),
    .st_drained(flags[0]), .st_saturated(flags[1]), .st_quiescent(flags[2]),
    .st_reading(flags[3]), .st_writing(flags[4]));

  initial begin
    forever #50 mclk = ~mclk;
  end

  // The command reaches the controller two edges later; every chosen step is a
  // self-loop under its own inputs, so the stale edge in between does no harm.
  task automatic go(input logic wr, input logic rd, input logic [7:0] lvl,
                    input logic [4:0] exp_st);
    @(posedge mclk);
    wr_cmd  <= wr;
    rd_cmd  <= rd;
    lvl_cmd <= lvl;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(flags, exp_st)
  endtask

  task automatic t_drained();
    go(1'b1, 1'b0, 8'hfa, D);
    go(1'b0, 1'b1, 8'h05, D);
    go(1'b1, 1'b0, 8'h05, W);
  endtask

  task automatic t_writing();
    go(1'b1, 1'b0, 8'hf9, W);
    go(1'b1, 1'b0, 8'hfa, S);
    go(1'b0, 1'b1, 8'h08, R);
    go(1'b1, 1'b0, 8'h01, W);
    go(1'b0, 1'b1, 8'h08, R);
    go(1'b1, 1'b0, 8'h02, W);
    go(1'b0, 1'b0, 8'h00, Q);
    go(1'b1, 1'b0, 8'h03, W);
    go(1'b0, 1'b1, 8'h00, D);
  endtask

  task automatic t_reading();
    go(1'b1, 1'b0, 8'h04, W);
    go(1'b0, 1'b1, 8'h09, R);
    go(1'b0, 1'b1, 8'h09, R);
    go(1'b1, 1'b0, 8'hfa, S);
    go(1'b0, 1'b1, 8'h01, R);
    go(1'b0, 1'b1, 8'h00, D);
    go(1'b1, 1'b0, 8'h00, W);
    go(1'b1, 1'b0, 8'hfa, S);
  endtask

  // Reset must wait for an edge, then win over a standing write at full level.
  task automatic t_mid_reset();
    @(posedge mclk);
    srst <= 1'b1;
    #1;
    `CHK(flags, S)
    @(posedge mclk);
    srst <= 1'b0;
    #1;
    `CHK(flags, D)
  endtask

  task automatic t_quiescent();
    go(1'b0, 1'b0, 8'h00, Q);
    go(1'b0, 1'b1, 8'h00, D);
    go(1'b0, 1'b0, 8'h00, Q);
    go(1'b0, 1'b1, 8'h07, R);
    go(1'b0, 1'b0, 8'h00, Q);
    go(1'b1, 1'b0, 8'hfa, S);
  endtask

  task automatic t_saturated();
    go(1'b1, 1'b0, 8'hfa, S);
    go(1'b0, 1'b0, 8'h00, Q);
    go(1'b1, 1'b0, 8'hfa, S);
    go(1'b0, 1'b1, 8'h03, R);
  endtask

  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #(2000 * 100);
    num_errors++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    #1;
    `CHK(flags, D)
    t_drained();
    t_writing();
    t_reading();
    t_mid_reset();
    t_quiescent();
    t_saturated();
    conclude();
  end
endmodule
